/* rtl/eig_ctrl.sv */
/*
  Global interrupt control word with external-interrupt edge polarity,
  APB register slave, sticky edge status with mask and level interrupt.
  Assumes a single APB master on pclk and interrupt sources on the core
  side presenting their individual enable-qualified requests.
*/
`timescale 1ns/1ns
// Contract
// [RL1] global enable gates maskable irqs, traps pass
// [RL2] disable-status bit reads 1 while timed disable
// [RL3] software-trap bit: 1 enabled, 0 disabled
// [RL4] polarity 1 falling edge, 0 rising edge
// [RL5] bits 12..3 read zero, writes ignored
// [RL6] synchronise inputs, one-cycle pulse on edge
module eig_ctrl
  import eig_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [EIG_NUM_EXT-1:0] ext_irq_in,
  input  wire logic                   maskable_irq_req,
  input  wire logic                   trap_req,
  output logic                        maskable_irq_out,
  output logic                        trap_out,
  output logic      [EIG_NUM_EXT-1:0] ext_irq_pulse,
  output logic                        irq
);
  typedef struct packed {
    logic                   global_irq_enable;
    logic                   timed_irq_disable_active;
    logic                   soft_trap_flag;
    logic [EIG_NUM_EXT-1:0] falling_select;
    logic [EIG_NUM_EXT-1:0] status;
    logic [EIG_NUM_EXT-1:0] mask;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   maskable_irq_out;
    logic                   trap_out;
    logic [EIG_NUM_EXT-1:0] ext_irq_pulse;
    logic                   irq;
  } eig_ctrl_state_t;

  eig_ctrl_state_t        st;
  eig_ctrl_state_t        next_st;
  eig_apb_req_t           req;
  logic [EIG_NUM_EXT-1:0] edge_pulse;
  logic                   access;
  logic                   wr;
  logic                   rd;
  logic [15:0]            gc_word;

  // one driver for the whole carrier, field order as the package declares
  assign req = {psel, penable, pwrite, paddr, pwdata};

  eig_edge_detect u_edge (
    .pclk           (pclk),
    .presetn        (presetn),
    .ext_irq_in     (ext_irq_in),
    .falling_select (st.falling_select),
    .edge_pulse     (edge_pulse)
  );

  // one wait state: answer in the access cycle after it is seen
  assign access = req.sel & req.enable & ~st.pready;
  assign wr     = access & req.write;
  assign rd     = access & ~req.write;

  always_comb
  begin
    gc_word = 16'h0000; // RL5
    gc_word[EIG_BIT_GIE]         = st.global_irq_enable;
    gc_word[EIG_BIT_DISABLE_ACT] = st.timed_irq_disable_active; // RL2
    gc_word[EIG_BIT_SOFT_TRAP]   = st.soft_trap_flag; // RL3
    gc_word[EIG_NUM_EXT-1:0]     = st.falling_select;
  end

  always_comb
  begin
    next_st         = st;
    next_st.pready  = access;
    next_st.pslverr = 1'b0;
    next_st.prdata  = 32'h0000_0000;
    next_st.ext_irq_pulse = edge_pulse;

    // events set status; a read in the same cycle does not lose them
    if (rd && req.addr == EIG_OFF_STATUS)
      next_st.status = edge_pulse;
    else
      next_st.status = st.status | edge_pulse;

    if (wr)
    begin
      case (req.addr)
        EIG_OFF_GLOBAL_CONTROL:
        begin
          // bits 14 and 13 are hardware status; only enable and polarity
          next_st.global_irq_enable = req.wdata[EIG_BIT_GIE];
          next_st.falling_select    = req.wdata[EIG_NUM_EXT-1:0]; // RL5
        end
        EIG_OFF_CONTROL:
        begin
          if (req.wdata[EIG_BIT_CTL_TIMED_IRQ_DISABLE_ACTIVE_SET])
            next_st.timed_irq_disable_active = 1'b1; // RL2
          else if (req.wdata[EIG_BIT_CTL_TIMED_IRQ_DISABLE_ACTIVE_CLR])
            next_st.timed_irq_disable_active = 1'b0; // RL2
          if (req.wdata[EIG_BIT_CTL_TRAP_SET])
            next_st.soft_trap_flag = 1'b1; // RL3
          else if (req.wdata[EIG_BIT_CTL_TRAP_CLR])
            next_st.soft_trap_flag = 1'b0; // RL3
        end
        EIG_OFF_STATUS: ;
        EIG_OFF_MASK:
          next_st.mask = req.wdata[EIG_NUM_EXT-1:0];
        default:
          next_st.pslverr = 1'b1;
      endcase
    end
    else if (rd)
    begin
      case (req.addr)
        EIG_OFF_GLOBAL_CONTROL:
          next_st.prdata = {16'h0000, gc_word};
        EIG_OFF_CONTROL:
          next_st.prdata = 32'h0000_0000;
        EIG_OFF_STATUS:
          next_st.prdata = {29'h0, st.status};
        EIG_OFF_MASK:
          next_st.prdata = {29'h0, st.mask};
        default:
          next_st.pslverr = 1'b1;
      endcase
    end

    // timed disable also holds maskable requests off
    next_st.maskable_irq_out = maskable_irq_req & st.global_irq_enable
                               & ~st.timed_irq_disable_active; // RL1
    next_st.trap_out = trap_req | st.soft_trap_flag; // RL1
    next_st.irq      = |(next_st.status & st.mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st                          <= '0;
      st.global_irq_enable        <= EIG_RST_GIE;
      st.timed_irq_disable_active <= EIG_RST_DISABLE_ACT;
      st.soft_trap_flag           <= EIG_RST_SOFT_TRAP;
      st.falling_select           <= EIG_RST_POLARITY;
      st.status                   <= EIG_RST_STATUS;
      st.mask                     <= EIG_RST_MASK;
    end
    else
      st <= next_st;
  end

  assign prdata           = st.prdata;
  assign pready           = st.pready;
  assign pslverr          = st.pslverr;
  assign maskable_irq_out = st.maskable_irq_out;
  assign trap_out         = st.trap_out;
  assign ext_irq_pulse    = st.ext_irq_pulse;
  assign irq              = st.irq;
endmodule

/* rtl/eig_pkg.sv */
/*
  Package for the external-interrupt global control block: register map,
  field positions, reset values and the shared carrier types.
  Assumes a 32-bit APB slave with word-aligned registers.
*/
package eig_pkg;
  localparam int         EIG_NUM_EXT            = 3;
  localparam logic [7:0] EIG_OFF_GLOBAL_CONTROL = 8'h00;
  localparam logic [7:0] EIG_OFF_CONTROL        = 8'h04;
  localparam logic [7:0] EIG_OFF_STATUS         = 8'h08;
  localparam logic [7:0] EIG_OFF_MASK           = 8'h0c;
  localparam int         EIG_BIT_GIE            = 15;
  localparam int         EIG_BIT_DISABLE_ACT    = 14;
  localparam int         EIG_BIT_SOFT_TRAP      = 13;
  localparam int         EIG_BIT_CTL_TIMED_IRQ_DISABLE_ACTIVE_SET   = 0;
  localparam int         EIG_BIT_CTL_TIMED_IRQ_DISABLE_ACTIVE_CLR   = 1;
  localparam int         EIG_BIT_CTL_TRAP_SET   = 2;
  localparam int         EIG_BIT_CTL_TRAP_CLR   = 3;
  localparam logic       EIG_RST_GIE            = 1'h1;
  localparam logic       EIG_RST_DISABLE_ACT    = 1'h0;
  localparam logic       EIG_RST_SOFT_TRAP      = 1'h0;
  localparam logic [2:0] EIG_RST_POLARITY       = 3'h0;
  localparam logic [2:0] EIG_RST_STATUS         = 3'h0;
  localparam logic [2:0] EIG_RST_MASK           = 3'h0;

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } eig_apb_req_t;

  typedef struct packed {
    logic [2:0] in_sync;
    logic [2:0] in_prev;
    logic [2:0] in_older;
    logic [2:0] pulse;
  } eig_edge_state_t;
endpackage

/* rtl/eig_edge_detect.sv */
/*
  Per-input edge detector for the external interrupt lines.
  Assumes the lines may be asynchronous; each passes two synchronising flops here before edges are compared.
*/
`timescale 1ns/1ns
module eig_edge_detect
  import eig_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [EIG_NUM_EXT-1:0] ext_irq_in,
  input  wire logic [EIG_NUM_EXT-1:0] falling_select,
  output logic      [EIG_NUM_EXT-1:0] edge_pulse
);
  eig_edge_state_t             st;
  eig_edge_state_t             next_st;
  wire logic [EIG_NUM_EXT-1:0] sel_edge;

  // only the prev stage reads the sync stage; edges compare prev with older
  genvar g;
  generate
    for (g = 0; g < EIG_NUM_EXT; g++)
    begin : g_edge
      assign sel_edge[g] = falling_select[g]
                         ? (st.in_older[g] & ~st.in_prev[g])  // RL4
                         : (~st.in_older[g] & st.in_prev[g]); // RL4
    end
  endgenerate

  always_comb
  begin
    next_st          = st;
    next_st.in_sync  = ext_irq_in;
    next_st.in_prev  = st.in_sync;
    next_st.in_older = st.in_prev;
    next_st.pulse    = sel_edge; // RL6
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign edge_pulse = st.pulse;
endmodule

/* test/eig_ctrl_properties.sv */
/*
  Port-level checker for eig_ctrl.
  Assumes one pclk domain with presetn as its asynchronous reset.
*/
`timescale 1ns/1ns
module eig_ctrl_properties
  import eig_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  ext_irq_in,
  input wire logic        maskable_irq_req,
  input wire logic        trap_req,
  input wire logic        maskable_irq_out,
  input wire logic        trap_out,
  input wire logic [2:0]  ext_irq_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_bound: assert property (psel && penable |-> ##[0:2] pready)
    else $error("access phase without pready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_maskable_gate: assert property (
    maskable_irq_out |-> $past(maskable_irq_req))
    else $error("maskable output without request");
  a_trap_pass: assert property (trap_req |=> trap_out)
    else $error("trap request blocked");
  a_reserved_zero: assert property (
    pready && !pwrite && paddr == EIG_OFF_GLOBAL_CONTROL
    |-> prdata[12:3] == 10'h0 && prdata[31:16] == 16'h0)
    else $error("unimplemented bits not zero");
  a_pulse_single: assert property (
    ext_irq_pulse != 3'h0 |=> (ext_irq_pulse & $past(ext_irq_pulse)) == 3'h0)
    else $error("edge pulse longer than one cycle");
  a_pulse_cause: assert property (
    ((($past(ext_irq_in, 4) ^ $past(ext_irq_in, 5)) & ext_irq_pulse)
    == ext_irq_pulse)) else $error("edge pulse without input change");
endmodule

bind eig_ctrl eig_ctrl_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_irq_in(ext_irq_in), .maskable_irq_req(maskable_irq_req),
  .trap_req(trap_req), .maskable_irq_out(maskable_irq_out),
  .trap_out(trap_out), .ext_irq_pulse(ext_irq_pulse));

/* test/eig_ctrl_bench.sv */
/*
  Self-checking bench for eig_ctrl, driving APB and the interrupt inputs.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ns
module eig_ctrl_bench
  import eig_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        mreq = 0, treq = 0, ph = 0, pready, pslverr, er;
  logic        mi_out, tr_out, irq;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, r;
  logic [2:0]  ext = 3'h0, pulse, seen_r, seen_f, p, m;
  int          err_total = 0, samples_checked = 0;
  eig_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq_in(ext),
    .maskable_irq_req(mreq), .trap_req(treq), .maskable_irq_out(mi_out),
    .trap_out(tr_out), .ext_irq_pulse(pulse), .irq(irq));
  always #5 pclk = ~pclk;
  // pulses gathered on the falling edge so clears from the main flow never race
  always @(negedge pclk)
    if (ph) seen_f = seen_f | pulse; else seen_r = seen_r | pulse;
  task print_verdict;
    $display("mismatches %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [31:0] exp_gc(input logic g, input logic d,
                                         input logic t, input logic [2:0] f);
    exp_gc                      = 32'h0;
    exp_gc[EIG_BIT_GIE]         = g;
    exp_gc[EIG_BIT_DISABLE_ACT] = d;
    exp_gc[EIG_BIT_SOFT_TRAP]   = t;
    exp_gc[2:0]                 = f;
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial
  begin
    repeat (5000) @(posedge pclk);
    err_total++;
    print_verdict;
  end
  initial
  begin
    r = $urandom(32'haee6);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, EIG_OFF_GLOBAL_CONTROL, 0);
    chk("control word reset", rd, exp_gc(1'h1, 1'h0, 1'h0, 3'h0));
    apb(0, EIG_OFF_MASK, 0);
    chk("mask reset", rd, 32'h0);
    apb(0, 8'h10, 0);
    chk("unmapped error", er, 1);
    chk("unmapped data", rd, 32'h0);
    mreq <= 1'b1;
    apb(1, EIG_OFF_CONTROL, 32'h1);
    apb(0, EIG_OFF_GLOBAL_CONTROL, 0);
    chk("timed disable on", rd, exp_gc(1'h1, 1'h1, 1'h0, 3'h0));
    chk("maskable blocked", mi_out, 0);
    apb(1, EIG_OFF_CONTROL, 32'h2);
    apb(0, EIG_OFF_GLOBAL_CONTROL, 0);
    chk("timed disable off", rd, exp_gc(1'h1, 1'h0, 1'h0, 3'h0));
    chk("maskable passed", mi_out, 1);
    apb(1, EIG_OFF_GLOBAL_CONTROL, 0);
    treq <= 1'b1;
    apb(1, EIG_OFF_CONTROL, 32'h4);
    apb(0, EIG_OFF_GLOBAL_CONTROL, 0);
    chk("soft trap on", rd, exp_gc(1'h0, 1'h0, 1'h1, 3'h0));
    chk("maskable gated", mi_out, 0);
    chk("trap passed", tr_out, 1);
    treq <= 1'b0;
    apb(1, EIG_OFF_CONTROL, 32'h8);
    apb(0, EIG_OFF_CONTROL, 0);
    chk("control reads zero", rd, 32'h0);
    chk("soft trap off", tr_out, 0);
    repeat (4)
    begin
      r = $urandom;
      apb(1, EIG_OFF_GLOBAL_CONTROL, r);
      apb(0, EIG_OFF_GLOBAL_CONTROL, 0);
      chk("control word", rd, exp_gc(r[EIG_BIT_GIE], 1'h0, 1'h0, r[2:0]));
    end
    for (int i = 0; i < 8; i++)
    begin
      p = 3'(i);
      m = 3'($urandom);
      apb(1, EIG_OFF_GLOBAL_CONTROL, 32'h8000 | p);
      apb(1, EIG_OFF_MASK, m);
      apb(0, EIG_OFF_STATUS, 0);
      seen_r = 3'h0;
      seen_f = 3'h0;
      ext <= 3'h7;
      repeat (8) @(posedge pclk);
      chk("rising pulses", seen_r, 3'(~p));
      ph = 1'b1;
      ext <= 3'h0;
      repeat (8) @(posedge pclk);
      chk("falling pulses", seen_f, p);
      chk("irq masked", irq, |m);
      apb(0, EIG_OFF_STATUS, 0);
      chk("status", rd, 32'h7);
      repeat (3) @(posedge pclk);
      chk("irq cleared", irq, 0);
      ph = 1'b0;
    end
    // mid-run reset with timed disable and soft trap both set
    apb(1, EIG_OFF_CONTROL, 32'h5);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, EIG_OFF_GLOBAL_CONTROL, 0);
    chk("word after reset", rd, exp_gc(1'h1, 1'h0, 1'h0, 3'h0));
    apb(1, 8'h10, 32'hffff_ffff);
    chk("unmapped write error", er, 1);
    apb(0, EIG_OFF_MASK, 0);
    chk("mask after reset", rd, 32'h0);
    print_verdict;
  end
endmodule
